// File: core/sync_two_stage.sv
`timescale 1ns/1ps
`default_nettype none

module sync_two_stage #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;

  // meta_q feeds only the second stage
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : sync_two_stage

`default_nettype wire

// File: core/timer_pkg.sv
// ----------------------------------------------------------------------
// Operation
// - timers 0 and 1 share a 10-bit prescaler with taps 8, 64, 256, 1024
// - timers 0 and 1 may also pick undivided clock, external pin, or stop
// - writing one to the shared reset bit clears the shared prescaler
// - shared reset bit self-clears, writing zero does nothing, reads zero
// - timer 2 prescaler runs on cpu clock unless async select is set
// - async select detaches both oscillator pins from general port use
// - timer 2 prescaler taps are 8, 32, 64, 128, 256 and 1024
// - writing one to timer 2 reset bit clears its prescaler, zero ignored
// - timer 2 reset bit reads zero in sync mode, one until done in async
// - upper six bits of the prescaler reset register read zero
// - timer 0 external pin is synchronised on rising cpu clock edges
// - overflow and compare flags share one flag register, enables one mask
// - control register holds force, pwm, mode[1:0], clear, select[2:0]
// - writing force applies the compare output action as if matched
// - force written with new mode uses the old mode
// - force raises no compare flag and never clears the counter
// - force bit reads zero and is ignored in pwm mode
// - pwm enable bit switches the timer into pwm operation
// - timer 0 select: stop, clk, 8, 64, 256, 1024, pin fall, pin rise
// - timer 2 select: stop, input, 8, 32, 64, 128, 256, 1024
// - outside pwm, mode 00 off, 01 toggle, 10 clear, 11 set on match
// ----------------------------------------------------------------------
`default_nettype none

package timer_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] T2_CTRL_ADDR  = 8'h27;
  localparam logic [7:0] T0_CTRL_ADDR  = 8'h33;
  localparam logic [7:0] PSR_ADDR      = 8'h30;
  localparam logic [7:0] ASYNC_ADDR    = 8'h22;
  localparam logic [7:0] FLAG_ADDR     = 8'h38;
  localparam logic [7:0] MASK_ADDR     = 8'h39;

  localparam int SHARED_RST_POS = 0;
  localparam int T2_RST_POS     = 1;
  localparam int ASYNC_SEL_POS  = 0;
  localparam int FORCE_POS      = 7;
  localparam int OVF_POS        = 0;
  localparam int CMP_POS        = 2;

  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [3:0] FLAG_RESET  = 4'h0;
  localparam logic [3:0] MASK_RESET  = 4'h0;

  // ----------------------------------------------------------------------
  // prescalers and selects
  // ----------------------------------------------------------------------
  localparam int PRESCALE_W = 10;
  localparam int T0_TAP_LOG2 [4] = '{3, 6, 8, 10};
  localparam int T2_TAP_LOG2 [6] = '{3, 5, 6, 7, 8, 10};

  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIRECT   = 3'h1;
  localparam logic [2:0] CS_TAP_BASE = 3'h2;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  typedef struct packed {
    logic       force_cmp;
    logic       pwm;
    logic [1:0] mode;
    logic       ctc;
    logic [2:0] cs;
  } ctrl_type;

endpackage : timer_pkg

`default_nettype wire

// File: core/timer_prescaler_control.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module timer_prescaler_control #(
  parameter int PRESCALE_W = timer_pkg::PRESCALE_W
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_t0_ext_clock_pin,
  input  wire logic       i_osc_input_pin,
  input  wire logic [1:0] i_compare_match,
  input  wire logic [1:0] i_overflow,
  output var  logic [7:0] o_rdata,
  output var  logic [1:0] o_count_en,
  output var  logic [1:0] o_counter_clear,
  output var  logic [1:0] o_compare_out,
  output var  logic [1:0] o_compare_oe,
  output var  logic [1:0] o_pwm_mode,
  output var  logic       o_osc_pins_detach
);

  // ----------------------------------------------------------------------
  // decode and pin synchronisers
  // ----------------------------------------------------------------------
  timer_pkg::ctrl_type   ctrl_q [2];
  logic [1:0]            wr_ctrl;
  logic                  wr_psr;
  logic                  wr_async;
  logic                  wr_flag;
  logic                  wr_mask;
  logic [1:0]            pins_s;
  logic                  t0_s;
  logic                  osc_s;
  logic                  t0_prev_q;
  logic                  osc_prev_q;
  logic                  t0_rise;
  logic                  t0_fall;

  assign wr_ctrl[0] = i_wr && (i_addr == timer_pkg::T0_CTRL_ADDR);
  assign wr_ctrl[1] = i_wr && (i_addr == timer_pkg::T2_CTRL_ADDR);
  assign wr_psr     = i_wr && (i_addr == timer_pkg::PSR_ADDR);
  assign wr_async   = i_wr && (i_addr == timer_pkg::ASYNC_ADDR);
  assign wr_flag    = i_wr && (i_addr == timer_pkg::FLAG_ADDR);
  assign wr_mask    = i_wr && (i_addr == timer_pkg::MASK_ADDR);

  sync_two_stage #(
    .WIDTH (2)
  ) u_pin_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_async   ({i_osc_input_pin, i_t0_ext_clock_pin}),
    .o_sync    (pins_s)
  );

  assign t0_s  = pins_s[0];
  assign osc_s = pins_s[1];

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      t0_prev_q  <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      t0_prev_q  <= t0_s;
      osc_prev_q <= osc_s;
    end
  end

  // one enable per selected edge, never per level
  assign t0_rise = t0_s && !t0_prev_q;
  assign t0_fall = !t0_s && t0_prev_q;

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q[0] <= timer_pkg::ctrl_type'(timer_pkg::CTRL_RESET);
      ctrl_q[1] <= timer_pkg::ctrl_type'(timer_pkg::CTRL_RESET);
    end else begin
      for (int t = 0; t < 2; t++) begin
        if (wr_ctrl[t]) begin
          // the force bit is never stored, so it reads back zero
          ctrl_q[t] <= timer_pkg::ctrl_type'({1'b0, i_wdata[6:0]});
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // shared prescaler for timers 0 and 1
  // ----------------------------------------------------------------------
  logic [PRESCALE_W-1:0] psc0_q;
  logic [3:0]            tap0;
  logic                  shared_rst;

  assign shared_rst = wr_psr && i_wdata[timer_pkg::SHARED_RST_POS];

  // a zero write leaves the count alone; the bit is a strobe only
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      psc0_q <= '0;
    end else if (shared_rst) begin
      psc0_q <= '0;
    end else begin
      psc0_q <= psc0_q + 1'b1;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_tap0
    localparam logic [PRESCALE_W-1:0] MASK =
      PRESCALE_W'((1 << timer_pkg::T0_TAP_LOG2[g]) - 1);
    assign tap0[g] = ((psc0_q & MASK) == MASK);
  end

  // ----------------------------------------------------------------------
  // timer 2 prescaler, fed by cpu clock or the oscillator pin
  // ----------------------------------------------------------------------
  logic                  async_q;
  logic                  t2_pending_q;
  logic                  t2_in_tick;
  logic                  t2_rst_req;
  logic [PRESCALE_W-1:0] psc2_q;
  logic [5:0]            tap2;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      async_q <= 1'b0;
    end else if (wr_async) begin
      async_q <= i_wdata[timer_pkg::ASYNC_SEL_POS];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_osc_pins_detach <= 1'b0;
    end else begin
      o_osc_pins_detach <= async_q;
    end
  end

  // the oscillator is slower than cpu/4, so a sampled rising edge marks
  // exactly one oscillator period
  assign t2_in_tick = async_q ? (osc_s && !osc_prev_q) : 1'b1;
  assign t2_rst_req = wr_psr && i_wdata[timer_pkg::T2_RST_POS];

  // in async mode the reset lands on the next oscillator tick; a new
  // request in that same cycle keeps the bit set
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      t2_pending_q <= 1'b0;
    end else if (t2_rst_req && async_q) begin
      t2_pending_q <= 1'b1;
    end else if (t2_in_tick || !async_q) begin
      t2_pending_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      psc2_q <= '0;
    end else if (t2_rst_req && !async_q) begin
      psc2_q <= '0;
    end else if (t2_in_tick) begin
      if (t2_pending_q) begin
        psc2_q <= '0;
      end else begin
        psc2_q <= psc2_q + 1'b1;
      end
    end
  end

  for (genvar g = 0; g < 6; g++) begin : g_tap2
    localparam logic [PRESCALE_W-1:0] MASK =
      PRESCALE_W'((1 << timer_pkg::T2_TAP_LOG2[g]) - 1);
    assign tap2[g] = t2_in_tick && ((psc2_q & MASK) == MASK);
  end

  // ----------------------------------------------------------------------
  // clock select decode
  // ----------------------------------------------------------------------
  logic [1:0] tick;
  logic [2:0] idx0;
  logic [2:0] idx2;

  assign idx0 = ctrl_q[0].cs - timer_pkg::CS_TAP_BASE;
  assign idx2 = ctrl_q[1].cs - timer_pkg::CS_TAP_BASE;

  always_comb begin
    tick = 2'h0;
    case (ctrl_q[0].cs)
      timer_pkg::CS_STOP:     tick[0] = 1'b0;
      timer_pkg::CS_DIRECT:   tick[0] = 1'b1;
      timer_pkg::CS_EXT_FALL: tick[0] = t0_fall;
      timer_pkg::CS_EXT_RISE: tick[0] = t0_rise;
      default:                tick[0] = tap0[idx0[1:0]];
    endcase
    case (ctrl_q[1].cs)
      timer_pkg::CS_STOP:   tick[1] = 1'b0;
      timer_pkg::CS_DIRECT: tick[1] = t2_in_tick;
      default: begin
        tick[1] = (idx2 < 3'h6) ? tap2[idx2] : 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_count_en <= 2'h0;
    end else begin
      o_count_en <= tick;
    end
  end

  // ----------------------------------------------------------------------
  // compare output, force and pwm
  // ----------------------------------------------------------------------
  for (genvar t = 0; t < 2; t++) begin : g_cmp
    logic force_hit;
    logic act;

    // force is a write strobe, ignored while pwm runs
    assign force_hit = wr_ctrl[t] && i_wdata[timer_pkg::FORCE_POS]
                       && !ctrl_q[t].pwm;
    assign act = !ctrl_q[t].pwm && (force_hit || i_compare_match[t]);

    // ctrl_q still holds the old mode in the write cycle
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
        o_compare_out[t] <= 1'b0;
      end else if (act) begin
        case (ctrl_q[t].mode)
          timer_pkg::COM_TOGGLE: o_compare_out[t] <= !o_compare_out[t];
          timer_pkg::COM_CLEAR:  o_compare_out[t] <= 1'b0;
          timer_pkg::COM_SET:    o_compare_out[t] <= 1'b1;
          default:               o_compare_out[t] <= o_compare_out[t];
        endcase
      end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
        o_compare_oe[t]    <= 1'b0;
        o_pwm_mode[t]      <= 1'b0;
        o_counter_clear[t] <= 1'b0;
      end else begin
        o_compare_oe[t] <= (ctrl_q[t].mode != timer_pkg::COM_OFF);
        o_pwm_mode[t]   <= ctrl_q[t].pwm;
        // only a real match clears the counter
        o_counter_clear[t] <= i_compare_match[t] && ctrl_q[t].ctc
                              && !ctrl_q[t].pwm;
      end
    end
  end

  // ----------------------------------------------------------------------
  // shared flag and mask registers
  // ----------------------------------------------------------------------
  logic [3:0] flags_q;
  logic [3:0] mask_q;
  logic [3:0] flag_set;

  // forced compares never reach the flag set term
  assign flag_set = {i_compare_match, i_overflow};

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flags_q <= timer_pkg::FLAG_RESET;
    end else begin
      // write one clears; a new event in that cycle survives
      flags_q <= (flags_q & ~(wr_flag ? i_wdata[3:0] : 4'h0))
                 | flag_set;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mask_q <= timer_pkg::MASK_RESET;
    end else if (wr_mask) begin
      mask_q <= i_wdata[3:0];
    end
  end

  // ----------------------------------------------------------------------
  // read port, data valid only in the cycle after the strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (!i_rd) begin
      o_rdata <= 8'h00;
    end else begin
      case (i_addr)
        timer_pkg::T0_CTRL_ADDR: o_rdata <= {1'b0, ctrl_q[0][6:0]};
        timer_pkg::T2_CTRL_ADDR: o_rdata <= {1'b0, ctrl_q[1][6:0]};
        timer_pkg::PSR_ADDR:
          o_rdata <= {6'h00, t2_pending_q, 1'b0};
        timer_pkg::ASYNC_ADDR:   o_rdata <= {7'h00, async_q};
        timer_pkg::FLAG_ADDR:    o_rdata <= {4'h0, flags_q};
        timer_pkg::MASK_ADDR:    o_rdata <= {4'h0, mask_q};
        default:                 o_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  logic force_hit0;
  assign force_hit0 = g_cmp[0].force_hit && !i_compare_match[0];

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  a_shared_psc_clear: assert property (
    shared_rst |=> psc0_q == '0)
    else $error("shared prescaler not cleared");

  a_psr_low_zero: assert property (
    i_rd && i_addr == timer_pkg::PSR_ADDR |=> !o_rdata[0] && o_rdata[7:2] == 0)
    else $error("prescaler reset register reads nonzero");

  a_t0_div1024: assert property (
    ctrl_q[0].cs == 3'h5 && psc0_q == '1 |=> o_count_en[0])
    else $error("missing divide by 1024 enable");

  a_t0_div8_gap: assert property (
    ctrl_q[0].cs == 3'h2 && psc0_q[2:0] != 3'h7 && !wr_ctrl[0]
    |=> !o_count_en[0])
    else $error("divide by 8 enable off phase");

  a_t0_ext_rise: assert property (
    ctrl_q[0].cs == timer_pkg::CS_EXT_RISE && t0_s && !t0_prev_q
    |=> o_count_en[0])
    else $error("external rising edge lost");

  a_t2_sync_reset: assert property (
    t2_rst_req && !async_q |=> psc2_q == '0 ##0 !t2_pending_q)
    else $error("sync timer 2 reset failed");

  a_t2_pending_hold: assert property (
    async_q && t2_pending_q && !t2_in_tick && !wr_async |=> t2_pending_q)
    else $error("async reset bit dropped early");

  a_force_old_mode: assert property (
    force_hit0 && ctrl_q[0].mode == timer_pkg::COM_SET
    |=> o_compare_out[0])
    else $error("force did not apply old set mode");

  a_force_no_clear: assert property (
    wr_ctrl[0] && i_wdata[7] && !i_compare_match[0]
    |=> !o_counter_clear[0])
    else $error("force cleared counter");

  a_force_pwm_off: assert property (
    wr_ctrl[0] && i_wdata[7] && ctrl_q[0].pwm && !i_compare_match[0]
    |=> $stable(o_compare_out[0]))
    else $error("force acted in pwm mode");

  a_flag_set_wins: assert property (
    i_overflow[0] |=> flags_q[0])
    else $error("overflow flag lost");

  c_force_toggle: cover property (
    force_hit0 && ctrl_q[0].mode == timer_pkg::COM_TOGGLE);
  c_async_reset_done: cover property (
    t2_pending_q ##1 !t2_pending_q && async_q);
  c_ext_fall_count: cover property (
    ctrl_q[0].cs == timer_pkg::CS_EXT_FALL ##1 o_count_en[0]);
  c_t2_div1024: cover property (
    ctrl_q[1].cs == 3'h7 ##1 o_count_en[1]);

endmodule : timer_prescaler_control

`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;

  // ----------------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------------
  localparam int LIMIT = 40000;

  logic       i_clk_sys = 1'b0;
  logic       i_rst_b   = 1'b0;
  logic [7:0] i_addr    = 8'h00;
  logic [7:0] i_wdata   = 8'h00;
  logic       i_wr      = 1'b0;
  logic       i_rd      = 1'b0;
  logic       t0_pin    = 1'b0;
  logic       osc_pin   = 1'b0;
  logic [1:0] match     = 2'h0;
  logic [1:0] ovf       = 2'h0;
  logic [7:0] o_rdata;
  logic [1:0] o_count_en;
  logic [1:0] o_counter_clear;
  logic [1:0] o_compare_out;
  logic [1:0] o_compare_oe;
  logic [1:0] o_pwm_mode;
  logic       o_osc_pins_detach;
  int         fails     = 0;
  int         n_tests   = 0;
  int         cycles    = 0;
  int         en_cnt [2] = '{0, 0};
  int         clr_cnt   = 0;

  timer_prescaler_control i_timer_prescaler_control (
    .i_clk_sys          (i_clk_sys),
    .i_rst_b            (i_rst_b),
    .i_addr             (i_addr),
    .i_wdata            (i_wdata),
    .i_wr               (i_wr),
    .i_rd               (i_rd),
    .i_t0_ext_clock_pin (t0_pin),
    .i_osc_input_pin    (osc_pin),
    .i_compare_match    (match),
    .i_overflow         (ovf),
    .o_rdata            (o_rdata),
    .o_count_en         (o_count_en),
    .o_counter_clear    (o_counter_clear),
    .o_compare_out      (o_compare_out),
    .o_compare_oe       (o_compare_oe),
    .o_pwm_mode         (o_pwm_mode),
    .o_osc_pins_detach  (o_osc_pins_detach)
  );

  always #12.5 i_clk_sys = ~i_clk_sys;

  // pulses are one cycle wide, so sampling each edge counts each once
  always @(posedge i_clk_sys) begin
    cycles++;
    for (int k = 0; k < 2; k++) begin
      if (o_count_en[k] === 1'b1) en_cnt[k]++;
      if (o_counter_clear[k] === 1'b1) clr_cnt++;
    end
    if (cycles == LIMIT) begin
      fails++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_clk_sys);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd   <= 1'b0;
    #1;
    v = o_rdata;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check(v, exp);
  endtask : rd_chk

  // cycles from now until the next count enable of timer k
  task automatic gap(input int k, output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (o_count_en[k] !== 1'b1 && n < 2100);
  endtask : gap

  task automatic toggle(input int w, input int n, input int hold);
    repeat (n) begin
      repeat (hold) @(posedge i_clk_sys);
      if (w == 0) t0_pin <= 1'b1;
      else osc_pin <= 1'b1;
      repeat (hold) @(posedge i_clk_sys);
      if (w == 0) t0_pin <= 1'b0;
      else osc_pin <= 1'b0;
    end
    tick(6);
  endtask : toggle

  task automatic evt(input logic [1:0] m, input logic [1:0] o);
    @(posedge i_clk_sys);
    match <= m;
    ovf   <= o;
    @(posedge i_clk_sys);
    match <= 2'h0;
    ovf   <= 2'h0;
    tick(3);
  endtask : evt

  function automatic int div(input int k, input int s);
    int t0 [5] = '{1, 8, 64, 256, 1024};
    int t2 [7] = '{1, 8, 32, 64, 128, 256, 1024};
    return (k == 0) ? t0[s-1] : t2[s-1];
  endfunction : div

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset_values;
    logic [7:0] addrs [7] = '{8'h33, 8'h27, 8'h30, 8'h22, 8'h38, 8'h39, 8'h00};
    check({o_count_en, o_counter_clear, o_compare_out, o_compare_oe,
           o_pwm_mode, o_osc_pins_detach}, 16'h0000);
    wr(8'h00, 8'hff);
    foreach (addrs[i]) rd_chk(addrs[i], 8'h00);
    $display("test reset_values done");
  endtask : t_reset_values

  task automatic t_selects(input int k);
    logic [7:0] a;
    int         n;
    a = (k == 0) ? 8'h33 : 8'h27;
    wr(a, 8'h00);
    tick(20);
    en_cnt[k] = 0;
    tick(100);
    check(16'(en_cnt[k]), 16'h0000);
    for (int s = 1; s < ((k == 0) ? 6 : 8); s++) begin
      wr(a, s[7:0]);
      gap(k, n);
      gap(k, n);
      check(16'(n), 16'(div(k, s)));
    end
    wr(a, 8'h00);
    $display("test selects %0d done", k);
  endtask : t_selects

  task automatic t_presc_reset(input int k);
    int n;
    wr((k == 0) ? 8'h33 : 8'h27, 8'h02);
    wr(8'h30, (k == 0) ? 8'h01 : 8'h02);
    gap(k, n);
    check(16'(n), 16'h0008);
    rd_chk(8'h30, 8'h00);
    gap(k, n);
    wr(8'h30, 8'h00);
    gap(k, n);
    check(16'(n), 16'h0006);
    gap(k, n);
    wr(8'h30, 8'hfc);
    gap(k, n);
    check(16'(n), 16'h0006);
    rd_chk(8'h30, 8'h00);
    wr((k == 0) ? 8'h33 : 8'h27, 8'h00);
    $display("test presc_reset %0d done", k);
  endtask : t_presc_reset

  task automatic t_ext_pin;
    for (int s = 7; s > 5; s--) begin
      wr(8'h33, s[7:0]);
      tick(4);
      en_cnt[0] = 0;
      toggle(0, 4, 3);
      check(16'(en_cnt[0]), 16'h0004);
    end
    wr(8'h33, 8'h00);
    $display("test ext_pin done");
  endtask : t_ext_pin

  task automatic t_compare;
    wr(8'h33, 8'h10);
    tick(2);
    check({o_compare_oe[0], o_compare_out[0]}, 16'h0002);
    wr(8'h33, 8'h90);
    tick(3);
    check(o_compare_out[0], 16'h0001);
    rd_chk(8'h33, 8'h10);
    wr(8'h33, 8'hb0);
    tick(3);
    check(o_compare_out[0], 16'h0000);
    rd_chk(8'h33, 8'h30);
    wr(8'h33, 8'h38);
    clr_cnt = 0;
    evt(2'h1, 2'h0);
    check(o_compare_out[0], 16'h0001);
    check(16'(clr_cnt), 16'h0001);
    rd_chk(8'h38, 8'h04);
    wr(8'h38, 8'h04);
    wr(8'h33, 8'h28);
    evt(2'h1, 2'h0);
    check(o_compare_out[0], 16'h0000);
    wr(8'h38, 8'h04);
    wr(8'h33, 8'hb8);
    wr(8'h33, 8'h98);
    tick(3);
    check(o_compare_out[0], 16'h0001);
    check(16'(clr_cnt), 16'h0002);
    rd_chk(8'h38, 8'h00);
    wr(8'h33, 8'h50);
    tick(2);
    check(o_pwm_mode[0], 16'h0001);
    wr(8'h33, 8'hd0);
    tick(3);
    check(o_compare_out[0], 16'h0001);
    wr(8'h33, 8'h00);
    tick(2);
    check({o_compare_oe[0], o_pwm_mode[0]}, 16'h0000);
    $display("test compare done");
  endtask : t_compare

  task automatic t_flags;
    evt(2'h0, 2'h2);
    rd_chk(8'h38, 8'h02);
    wr(8'h27, 8'h38);
    clr_cnt = 0;
    evt(2'h2, 2'h1);
    rd_chk(8'h38, 8'h0b);
    check({o_compare_oe[1], o_compare_out[1]}, 16'h0003);
    check(16'(clr_cnt), 16'h0001);
    wr(8'h27, 8'h40);
    tick(2);
    check(o_pwm_mode[1], 16'h0001);
    wr(8'h27, 8'h00);
    wr(8'h38, 8'h0f);
    rd_chk(8'h38, 8'h00);
    wr(8'h39, 8'h0f);
    rd_chk(8'h39, 8'h0f);
    wr(8'h39, 8'h05);
    rd_chk(8'h39, 8'h05);
    $display("test flags done");
  endtask : t_flags

  task automatic t_async;
    wr(8'h22, 8'h01);
    tick(2);
    check(o_osc_pins_detach, 16'h0001);
    wr(8'h27, 8'h01);
    tick(4);
    en_cnt[1] = 0;
    tick(40);
    check(16'(en_cnt[1]), 16'h0000);
    wr(8'h30, 8'h02);
    rd_chk(8'h30, 8'h02);
    // osc edges 8 cycles apart keep it well below a quarter of the clock
    toggle(1, 3, 8);
    rd_chk(8'h30, 8'h00);
    check(16'(en_cnt[1]), 16'h0003);
    wr(8'h27, 8'h00);
    wr(8'h22, 8'h00);
    tick(2);
    check(o_osc_pins_detach, 16'h0000);
    $display("test async done");
  endtask : t_async

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    tick(1);
    t_reset_values();
    t_selects(0);
    t_selects(1);
    t_presc_reset(0);
    t_presc_reset(1);
    t_ext_pin();
    t_compare();
    t_flags();
    t_async();
    end_of_test();
  end

endmodule : tb_top

`default_nettype wire
